/* File: hw/gsc_counter.sv */
// Gated sixteen-bit up-counter with prescaler, gate logic and flags.
// Assumes one 100 MHz clock; pins and comparators arrive unsynchronised.
//
// Summary of operation
// [RL1] Sync disabled: count on raw edge path
// [RL2] Async external clock keeps counting in sleep
// [RL3] Mode switch may drop or add one
// [RL4] Byte reads always return settled counter bytes
// [RL5] Software stops counter before writing bytes
// [RL6] Gated: count only while gate active
// [RL7] Gate active when level equals polarity
// [RL8] Select: pin, timer wrap, comp1, comp2
// [RL9] Eight-bit timer wrap makes gate pulse
// [RL10] Comparator gate optionally latched on clock
// [RL11] Toggle flip-flop toggles; cleared when off
// [RL12] Software never enables toggle with polarity change
// [RL13] Go arms, starts on edge, clears trailing
// [RL14] After pulse, no counting until go
// [RL15] Software clears go when disabling mode
// [RL16] Toggle and single-pulse work together
// [RL17] Gate level status always shows gate
// [RL18] Falling gate level sets event flag
// [RL19] Event flag works with gating disabled
// [RL20] Rollover sets sticky overflow flag
// [RL21] Software sets all enables for interrupts
// [RL22] Sleep counting only asynchronous; overflow wakes
// [RL23] Runs only when on; gate if enabled
// [RL24] Prescaler divides by 1, 2, 4, 8
// [RL25] Synchronised mode adds aligned edge stage
`timescale 1ns/10ps

module gsc_counter (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire gsc_pkg::gsc_cfg_t    cfg,
    input  wire gsc_pkg::gsc_wr_t     wr,
    input  wire gsc_pkg::gsc_sw_t     sw,
    input  wire gsc_pkg::gsc_irq_en_t irq_en,
    input  wire logic                 sleep_mode,
    input  wire logic                 counter_clock,
    input  wire logic                 gate_input_pin,
    input  wire logic                 comparator1_gate_out,
    input  wire logic                 comparator2_gate_out,
    input  wire logic [7:0]           eight_bit_timer_count,
    output logic [15:0]               count_value,
    output logic [7:0]                count_low_byte,
    output logic [7:0]                count_high_byte,
    output logic                      overflow_flag,
    output logic                      gate_event_flag,
    output logic                      gate_level_status,
    output logic                      single_pulse_go,
    output logic                      irq_request,
    output logic                      wake_request
);

    // ========================================================
    // Input synchronisers
    logic [3:0]                 sync1_r;
    logic [3:0]                 sync2_r;
    logic                       edge_prev_r;
    logic                       align_r;
    logic                       align_prev_r;
    logic                       clk_edge;

    // Two stages for clock, gate pin and both comparators
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_r <= gsc_pkg::SYNC_RST;
            sync2_r <= gsc_pkg::SYNC_RST;
        end else begin
            sync1_r <= {comparator2_gate_out, comparator1_gate_out,
                        gate_input_pin, counter_clock};
            sync2_r <= sync1_r;
        end
    end

    // Edge detection on both counting paths
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            edge_prev_r  <= 1'b0;
            align_r      <= 1'b0;
            align_prev_r <= 1'b0;
        end else begin
            edge_prev_r  <= sync2_r[0];
            align_r      <= sync2_r[0];  // [RL25]
            align_prev_r <= align_r;
        end
    end

    // Raw path when unsynchronised, aligned path otherwise
    always_comb begin
        if (cfg.clock_sync_disable) begin
            clk_edge = sync2_r[0] & ~edge_prev_r;  // [RL1]
        end else begin
            clk_edge = align_r & ~align_prev_r;    // [RL25] [RL3]
        end
    end

    // ========================================================
    // Gate source selection
    logic [7:0]                 t0_prev_r;
    logic                       t0_pulse_r;
    logic [1:0]                 comp_lat_r;
    logic [1:0]                 comp_gate;
    logic                       gate_sel;
    logic                       src_act;
    logic                       src_prev_r;
    logic                       tog_r;
    logic                       gate_a;
    logic                       gate_a_prev_r;

    // Pulse on eight-bit timer wrap
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            t0_prev_r  <= gsc_pkg::T0_ZERO;
            t0_pulse_r <= 1'b0;
        end else begin
            t0_prev_r  <= eight_bit_timer_count;
            t0_pulse_r <= (t0_prev_r == gsc_pkg::T0_MAX) &&
                          (eight_bit_timer_count == gsc_pkg::T0_ZERO);  // [RL9]
        end
    end

    // Comparator outputs latched on counter clock edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            comp_lat_r <= 2'h0;
        end else if (clk_edge) begin
            comp_lat_r <= sync2_r[3:2];  // [RL10]
        end
    end

    assign comp_gate = cfg.comp_sync_enable ? comp_lat_r : sync2_r[3:2];  // [RL10]

    // Source multiplexer
    always_comb begin
        case (cfg.gate_source_select)  // [RL8]
            gsc_pkg::GSRC_PIN: gate_sel = sync2_r[1];
            gsc_pkg::GSRC_T0:  gate_sel = t0_pulse_r;
            gsc_pkg::GSRC_C1:  gate_sel = comp_gate[0];
            gsc_pkg::GSRC_C2:  gate_sel = comp_gate[1];
            default:           gate_sel = sync2_r[1];
        endcase
    end

    assign src_act = ~(gate_sel ^ cfg.gate_polarity);  // [RL7]

    // Toggle flip-flop on active-going source edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_prev_r <= 1'b0;
            tog_r      <= 1'b0;
        end else begin
            src_prev_r <= src_act;
            if (!cfg.gate_toggle_mode || !cfg.counter_on) begin
                tog_r <= 1'b0;  // [RL11]
            end else if (src_act && !src_prev_r) begin
                tog_r <= ~tog_r;  // [RL11]
            end
        end
    end

    assign gate_a = cfg.gate_toggle_mode ? tog_r : src_act;  // [RL16]

    // ========================================================
    // Single-pulse acquisition
    gsc_pkg::gsc_sp_state_t     sp_r;
    gsc_pkg::gsc_sp_state_t     sp_nxt;
    logic                       gate_rise;
    logic                       gate_fall;
    logic                       gate_final;

    assign gate_rise = gate_a & ~gate_a_prev_r;
    assign gate_fall = ~gate_a & gate_a_prev_r;

    // Next acquisition state
    always_comb begin
        sp_nxt = sp_r;
        if (!cfg.gate_single_pulse_mode) begin
            sp_nxt = gsc_pkg::GSC_SP_IDLE;
        end else begin
            case (sp_r)
                gsc_pkg::GSC_SP_IDLE: begin
                    if (sw.go_set) begin
                        sp_nxt = gsc_pkg::GSC_SP_ARMED;
                    end
                end
                gsc_pkg::GSC_SP_ARMED: begin
                    if (sw.go_clear) begin
                        sp_nxt = gsc_pkg::GSC_SP_IDLE;
                    end else if (gate_rise) begin
                        sp_nxt = gsc_pkg::GSC_SP_COUNT;  // [RL13]
                    end
                end
                gsc_pkg::GSC_SP_COUNT: begin
                    if (sw.go_clear || gate_fall) begin
                        sp_nxt = gsc_pkg::GSC_SP_IDLE;  // [RL13] [RL14]
                    end
                end
                default: sp_nxt = gsc_pkg::GSC_SP_IDLE;
            endcase
        end
    end

    // State register and gate history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp_r          <= gsc_pkg::GSC_SP_IDLE;
            gate_a_prev_r <= 1'b0;
        end else begin
            sp_r          <= sp_nxt;
            gate_a_prev_r <= gate_a;
        end
    end

    // Counting window only inside an acquisition
    assign gate_final = cfg.gate_single_pulse_mode ?
                        (gate_a && sp_r == gsc_pkg::GSC_SP_COUNT) : gate_a;  // [RL14]

    assign single_pulse_go = (sp_r != gsc_pkg::GSC_SP_IDLE);

    // ========================================================
    // Gate status and event flag
    logic                       gate_level_r;
    logic                       gev_flag_r;

    // Level follows the gate regardless of gate enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gate_level_r <= 1'b0;
        end else begin
            gate_level_r <= gate_final;  // [RL17]
        end
    end

    // Sticky flag, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gev_flag_r <= 1'b0;
        end else if (gate_level_r && !gate_final) begin
            gev_flag_r <= 1'b1;  // [RL18] [RL19]
        end else if (sw.gate_event_clear) begin
            gev_flag_r <= 1'b0;
        end
    end

    assign gate_level_status = gate_level_r;
    assign gate_event_flag   = gev_flag_r;

    // ========================================================
    // Prescaler and counter
    logic                       run;
    logic [2:0]                 pre_r;
    logic [2:0]                 pre_mask;
    logic                       pre_done;
    logic                       tick;
    logic                       any_wr;
    logic [15:0]                count_r;
    logic                       ovf_flag_r;

    // Enable table and sleep restriction
    assign run = cfg.counter_on && (!cfg.gate_enable || gate_final) &&
                 (!sleep_mode || cfg.clock_sync_disable);  // [RL6] [RL23] [RL2] [RL22]

    assign pre_mask = 3'((4'h1 << cfg.prescale_select) - 4'h1);  // [RL24]
    assign pre_done = ((pre_r & pre_mask) == pre_mask);
    assign tick     = clk_edge && run && pre_done;
    assign any_wr   = wr.wr_low || wr.wr_high;

    // Prescale counter, cleared by byte writes
    always_ff @(posedge clk) begin
        if (sys_rst || any_wr) begin
            pre_r <= gsc_pkg::PRE_RST;
        end else if (clk_edge && run) begin
            pre_r <= pre_done ? gsc_pkg::PRE_RST : pre_r + gsc_pkg::PRE_ONE;  // [RL24]
        end
    end

    // Count register, writes take precedence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_r <= gsc_pkg::CNT_RST;
        end else if (any_wr) begin
            if (wr.wr_low) begin
                count_r[7:0] <= wr.wr_data;  // [RL5]
            end
            if (wr.wr_high) begin
                count_r[15:8] <= wr.wr_data;
            end
        end else if (tick) begin
            count_r <= count_r + gsc_pkg::CNT_ONE;  // [RL6]
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_flag_r <= 1'b0;
        end else if (tick && !any_wr && count_r == gsc_pkg::CNT_MAX) begin
            ovf_flag_r <= 1'b1;  // [RL20]
        end else if (sw.overflow_clear) begin
            ovf_flag_r <= 1'b0;
        end
    end

    // Settled bytes straight from the count register
    assign count_value     = count_r;
    assign count_low_byte  = count_r[7:0];   // [RL4]
    assign count_high_byte = count_r[15:8];  // [RL4]
    assign overflow_flag   = ovf_flag_r;

    // Interrupt request and sleep wake
    assign irq_request = ((ovf_flag_r && irq_en.overflow_irq_enable) ||
                          (gev_flag_r && irq_en.gate_event_irq_enable)) &&
                         irq_en.peripheral_irq_enable && irq_en.global_irq_enable;  // [RL18]
    assign wake_request = sleep_mode && ovf_flag_r && irq_en.overflow_irq_enable &&
                          irq_en.peripheral_irq_enable;  // [RL22] [RL2]

    // ========================================================
    // Assertions
    a_ovf_set: assert property (@(posedge clk) disable iff (sys_rst)  // [RL20]
        (tick && !any_wr && count_r == gsc_pkg::CNT_MAX) |=> (ovf_flag_r && count_r == 16'h0000))
        else $error("overflow flag not set on rollover");

    a_ovf_sticky: assert property (@(posedge clk) disable iff (sys_rst)  // [RL20]
        (ovf_flag_r && !sw.overflow_clear) |=> ovf_flag_r)
        else $error("overflow flag dropped without clear");

    a_gate_hold: assert property (@(posedge clk) disable iff (sys_rst)  // [RL6]
        (cfg.gate_enable && !gate_final && !any_wr) |=> $stable(count_r))
        else $error("count moved while gate inactive");

    a_off_hold: assert property (@(posedge clk) disable iff (sys_rst)  // [RL23]
        (!cfg.counter_on && !any_wr) |=> (count_r == $past(count_r)))
        else $error("count moved while counter off");

    a_gate_polarity: assert property (@(posedge clk) disable iff (sys_rst)  // [RL7]
        (!cfg.gate_toggle_mode && !cfg.gate_single_pulse_mode) |-> (gate_final == (gate_sel == cfg.gate_polarity)))
        else $error("gate activity does not match polarity");

    a_event_flag: assert property (@(posedge clk) disable iff (sys_rst)  // [RL18]
        $fell(gate_level_r) |-> gev_flag_r)
        else $error("falling gate level did not set event flag");

    a_toggle_clear: assert property (@(posedge clk) disable iff (sys_rst)  // [RL11]
        !cfg.gate_toggle_mode [*2] |-> !tog_r)
        else $error("toggle flip-flop not held clear");

    a_timer_pulse: assert property (@(posedge clk) disable iff (sys_rst)  // [RL9]
        (eight_bit_timer_count == 8'hFF) ##1 (eight_bit_timer_count == 8'h00) |=> t0_pulse_r ##1 !t0_pulse_r)
        else $error("timer wrap pulse missing or too long");

    a_go_done: assert property (@(posedge clk) disable iff (sys_rst)  // [RL13]
        (cfg.gate_single_pulse_mode && sp_r == gsc_pkg::GSC_SP_COUNT && gate_fall) |=> !single_pulse_go)
        else $error("go bit not cleared at trailing edge");

    a_sleep_sync: assert property (@(posedge clk) disable iff (sys_rst)  // [RL22]
        (sleep_mode && !cfg.clock_sync_disable && !any_wr) |=> $stable(count_r))
        else $error("synchronised counter moved in sleep");

endmodule

/* File: hw/gsc_pkg.sv */
// Constants, types and states shared by the gated sixteen-bit counter.
// Assumes a single system clock domain; no imports are used.
package gsc_pkg;

    // ========================================================
    // Widths and values
    localparam int          CNT_W     = 16;
    localparam int          PRE_W     = 3;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;
    localparam logic [2:0]  PRE_RST   = 3'h0;
    localparam logic [2:0]  PRE_ONE   = 3'h1;
    localparam logic [7:0]  T0_MAX    = 8'hFF;
    localparam logic [7:0]  T0_ZERO   = 8'h00;
    localparam logic [3:0]  SYNC_RST  = 4'h0;

    // ========================================================
    // Gate source codes
    localparam logic [1:0]  GSRC_PIN  = 2'h0;
    localparam logic [1:0]  GSRC_T0   = 2'h1;
    localparam logic [1:0]  GSRC_C1   = 2'h2;
    localparam logic [1:0]  GSRC_C2   = 2'h3;

    // ========================================================
    // Single-pulse acquisition states
    typedef enum logic [2:0] {
        GSC_SP_IDLE  = 3'b001,
        GSC_SP_ARMED = 3'b010,
        GSC_SP_COUNT = 3'b100
    } gsc_sp_state_t;

    // Control and configuration bits
    typedef struct packed {
        logic       counter_on;
        logic       clock_sync_disable;
        logic [1:0] prescale_select;
        logic       gate_enable;
        logic       gate_polarity;
        logic       gate_toggle_mode;
        logic       gate_single_pulse_mode;
        logic [1:0] gate_source_select;
        logic       comp_sync_enable;
    } gsc_cfg_t;

    // Byte writes to the count
    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] wr_data;
    } gsc_wr_t;

    // Software strobes
    typedef struct packed {
        logic go_set;
        logic go_clear;
        logic overflow_clear;
        logic gate_event_clear;
    } gsc_sw_t;

    // Interrupt enables
    typedef struct packed {
        logic overflow_irq_enable;
        logic gate_event_irq_enable;
        logic peripheral_irq_enable;
        logic global_irq_enable;
    } gsc_irq_en_t;

endpackage

/* File: verification/gsc_far_model.sv */
// Far-side stand-in: external counter clock, gate pin, comparators, 8-bit timer.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/10ps

module gsc_far_model (
    input  wire logic       clk,
    output logic            counter_clock,
    output logic            gate_pin,
    output logic            comp1,
    output logic            comp2,
    output logic [7:0]      timer_count
);

    // ========================================================
    // Idle levels: clock stands still low between bursts
    initial begin
        counter_clock = 1'h0;
        gate_pin = 1'h0;
        comp1 = 1'h0;
        comp2 = 1'h0;
        timer_count = 8'h40;
    end

    // Clock burst, each level held four cycles
    task automatic pulses(input int n);
        repeat (n) begin
            counter_clock = 1'h1;
            repeat (4) @(posedge clk);
            #1;
            counter_clock = 1'h0;
            repeat (4) @(posedge clk);
            #1;
        end
    endtask

    // Gate pin and comparator levels, then settle
    task automatic lines(input logic p, input logic a, input logic b);
        gate_pin = p;
        comp1 = a;
        comp2 = b;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Timer passes from its maximum to zero
    task automatic wrap();
        timer_count = 8'hFF;
        @(posedge clk);
        #1;
        timer_count = 8'h00;
        repeat (8) @(posedge clk);
        #1;
        timer_count = 8'h40;
    endtask

endmodule

/* File: verification/tb.sv */
// Self-checking bench for the gated sixteen-bit counter.
// Assumes gsc_pkg and gsc_counter are compiled first.
`timescale 1ns/10ps

module tb;

    logic                 clk;
    logic                 sys_rst;
    logic                 sleep_mode;
    gsc_pkg::gsc_cfg_t    cfg;
    gsc_pkg::gsc_wr_t     wr;
    gsc_pkg::gsc_sw_t     sw;
    gsc_pkg::gsc_irq_en_t irq_en;
    logic [15:0]          cnt;
    logic [7:0]           lo;
    logic [7:0]           hi;
    logic                 ovf;
    logic                 gev;
    logic                 lvl;
    logic                 go;
    logic                 irq;
    logic                 wake;
    logic                 cc;
    logic                 pin;
    logic                 c1;
    logic                 c2;
    logic [7:0]           t0;
    int                   n_errors = 0;
    int                   checked = 0;

    // ========================================================
    // Instances
    gsc_counter dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .wr(wr), .sw(sw), .irq_en(irq_en),
        .sleep_mode(sleep_mode), .counter_clock(cc), .gate_input_pin(pin), .comparator1_gate_out(c1),
        .comparator2_gate_out(c2), .eight_bit_timer_count(t0), .count_value(cnt), .count_low_byte(lo),
        .count_high_byte(hi), .overflow_flag(ovf), .gate_event_flag(gev), .gate_level_status(lvl),
        .single_pulse_go(go), .irq_request(irq), .wake_request(wake));
    gsc_far_model far (.clk(clk), .counter_clock(cc), .gate_pin(pin), .comp1(c1), .comp2(c2),
        .timer_count(t0));

    // Clock, 10 ns period
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ========================================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle strobe: 8 go_set, 4 go_clear, 2 overflow_clear, 1 gate_event_clear
    task automatic sw_pulse(input logic [3:0] s);
        sw = s;
        step(1);
        sw = 4'h0;
        step(2);
    endtask

    // Both bytes written with the counter stopped
    task automatic wr_count(input logic [15:0] v);
        logic on;
        on = cfg.counter_on;
        cfg.counter_on = 1'h0;
        wr = {1'h1, 1'h0, v[7:0]};
        step(1);
        wr = {1'h0, 1'h1, v[15:8]};
        step(1);
        wr = 10'h000;
        cfg.counter_on = on;
        step(2);
    endtask

    task automatic conclude();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_free();
        cfg = 11'h000;
        far.pulses(3);
        check_cnt("off", 16'h0000, cnt);
        cfg = 11'h600;
        far.pulses(5);
        check_cnt("async", 16'h0005, cnt);
        cfg.clock_sync_disable = 1'h0;
        far.pulses(5);
        check_cnt("sync", 16'h000A, cnt);
        cfg.clock_sync_disable = 1'h1;
        for (int ps = 0; ps < 4; ps++) begin
            cfg.prescale_select = ps[1:0];
            wr_count(16'h0000);
            far.pulses(8);
            check_cnt("prescale", 16'(8 >> ps), cnt);
        end
        cfg.prescale_select = 2'h0;
        wr_count(16'h55AA);
        check_cnt("bytes", 16'h55AA, {hi, lo});
    endtask

    task automatic t_gate();
        cfg = 11'h600;
        cfg.gate_enable = 1'h1;
        for (int i = 0; i < 4; i++) begin
            cfg.gate_polarity = i[1];
            far.lines(i[0], 1'h0, 1'h0);
            wr_count(16'h0000);
            far.pulses(3);
            check_cnt("gated", (i[1] == i[0]) ? 16'h0003 : 16'h0000, cnt);
            check_bit("level", i[1] == i[0], lvl);
        end
        cfg.gate_enable = 1'h0;
        far.lines(1'h0, 1'h0, 1'h0);
        wr_count(16'h0000);
        far.pulses(2);
        check_cnt("ungated", 16'h0002, cnt);
        check_bit("level off", 1'h0, lvl);
        cfg.gate_enable = 1'h1;
        for (int s = 2; s < 4; s++) begin
            cfg.gate_source_select = s[1:0];
            far.lines(1'h0, s == 2, s == 3);
            wr_count(16'h0000);
            far.pulses(2);
            check_cnt("comp on", 16'h0002, cnt);
            far.lines(1'h1, s == 3, s == 2);
            wr_count(16'h0000);
            far.pulses(2);
            check_cnt("comp off", 16'h0000, cnt);
        end
        cfg.comp_sync_enable = 1'h1;
        cfg.gate_source_select = gsc_pkg::GSRC_C1;
        far.lines(1'h0, 1'h0, 1'h0);
        far.pulses(1);
        far.lines(1'h0, 1'h1, 1'h0);
        check_bit("comp held", 1'h0, lvl);
        far.pulses(1);
        check_bit("comp latched", 1'h1, lvl);
        cfg.comp_sync_enable = 1'h0;
        cfg.gate_enable = 1'h0;
        cfg.gate_source_select = gsc_pkg::GSRC_T0;
        far.lines(1'h0, 1'h0, 1'h0);
        sw_pulse(4'h1);
        check_bit("event clr", 1'h0, gev);
        far.wrap();
        check_bit("event", 1'h1, gev);
        irq_en = 4'h7;
        step(1);
        check_bit("event irq", 1'h1, irq);
        irq_en = 4'hB;
        step(1);
        check_bit("event irq off", 1'h0, irq);
        irq_en = 4'hD;
        step(1);
        check_bit("event irq pie", 1'h0, irq);
        irq_en = 4'h0;
        sw_pulse(4'h1);
        check_bit("event clr2", 1'h0, gev);
    endtask

    task automatic t_overflow();
        cfg = 11'h600;
        irq_en = 4'hF;
        wr_count(16'hFFFF);
        far.pulses(1);
        check_cnt("wrap", 16'h0000, cnt);
        check_bit("irq", 1'h1, irq);
        far.pulses(1);
        check_bit("sticky", 1'h1, ovf);
        irq_en.global_irq_enable = 1'h0;
        step(1);
        check_bit("irq gie", 1'h0, irq);
        sw_pulse(4'h2);
        check_bit("ovf clr", 1'h0, ovf);
        sleep_mode = 1'h1;
        wr_count(16'hFFFF);
        far.pulses(1);
        check_cnt("sleep cnt", 16'h0000, cnt);
        check_bit("wake", 1'h1, wake);
        check_bit("sleep irq", 1'h0, irq);
        irq_en.overflow_irq_enable = 1'h0;
        step(1);
        check_bit("wake ie", 1'h0, wake);
        cfg.clock_sync_disable = 1'h0;
        far.pulses(2);
        check_cnt("sleep sync", 16'h0000, cnt);
        sleep_mode = 1'h0;
        irq_en = 4'h0;
        sw_pulse(4'h2);
    endtask

    task automatic t_toggle();
        logic [15:0] base;
        cfg = 11'h600;
        cfg.gate_enable = 1'h1;
        cfg.gate_polarity = 1'h1;
        far.lines(1'h0, 1'h0, 1'h0);
        cfg.gate_toggle_mode = 1'h1;
        far.lines(1'h1, 1'h0, 1'h0);
        check_bit("tog rise", 1'h1, lvl);
        far.lines(1'h0, 1'h0, 1'h0);
        check_bit("tog hold", 1'h1, lvl);
        base = cnt;
        far.pulses(2);
        check_cnt("tog cnt", base + 16'h0002, cnt);
        cfg.gate_toggle_mode = 1'h0;
        step(8);
        cfg.gate_toggle_mode = 1'h1;
        step(8);
        check_bit("tog clr", 1'h0, lvl);
    endtask

    task automatic t_single();
        cfg = 11'h600;
        cfg.gate_enable = 1'h1;
        cfg.gate_polarity = 1'h1;
        step(2);
        cfg.gate_single_pulse_mode = 1'h1;
        far.lines(1'h0, 1'h0, 1'h0);
        wr_count(16'h0000);
        sw_pulse(4'h8);
        check_bit("go", 1'h1, go);
        far.pulses(2);
        check_cnt("armed", 16'h0000, cnt);
        far.lines(1'h1, 1'h0, 1'h0);
        far.pulses(3);
        check_cnt("pulse", 16'h0003, cnt);
        far.lines(1'h0, 1'h0, 1'h0);
        check_bit("done", 1'h0, go);
        far.lines(1'h1, 1'h0, 1'h0);
        far.pulses(2);
        check_cnt("after", 16'h0003, cnt);
        far.lines(1'h0, 1'h0, 1'h0);
        cfg.gate_toggle_mode = 1'h1;
        wr_count(16'h0000);
        sw_pulse(4'h8);
        far.lines(1'h1, 1'h0, 1'h0);
        far.pulses(2);
        far.lines(1'h0, 1'h0, 1'h0);
        far.pulses(2);
        check_bit("period go", 1'h1, go);
        far.lines(1'h1, 1'h0, 1'h0);
        check_cnt("period", 16'h0004, cnt);
        check_bit("period done", 1'h0, go);
        sw_pulse(4'h8);
        check_bit("rearm", 1'h1, go);
        sw_pulse(4'h4);
        check_bit("abort", 1'h0, go);
        cfg.gate_single_pulse_mode = 1'h0;
        sw_pulse(4'h4);
    endtask

    // ========================================================
    // Main sequence
    initial begin
        sys_rst = 1'h1;
        sleep_mode = 1'h0;
        cfg = 11'h000;
        wr = 10'h000;
        sw = 4'h0;
        irq_en = 4'h0;
        step(20);
        sys_rst = 1'h0;
        step(2);
        check_cnt("reset cnt", 16'h0000, cnt);
        check_bit("reset ovf", 1'h0, ovf);
        check_bit("reset go", 1'h0, go);
        t_free();
        t_gate();
        t_overflow();
        t_toggle();
        t_single();
        conclude();
    end

    // Watchdog, far beyond the expected run
    initial begin
        #300000;
        n_errors++;
        conclude();
    end

endmodule
